/* include/epi_pkg.sv */
// Package of constants and types for the external pin interrupt latch.
// Overview of operation
// - A low condition on the active-low pin sets the request latch and raises a pending request.
// - A vector fetch of this interrupt produces an acknowledge that clears the latch.
// - Writing one to the acknowledge bit acts as an acknowledge and clears the latch.
// - Reset clears the request latch.
// - The select bit picks falling-edge only (0) or edge and low level (1), and reset clears it.
// - In edge-and-level mode the latch clears only once both an acknowledge and a high pin have occurred, in either order.
// - In edge-and-level mode the request stays pending while the pin stays low, even after an acknowledge.
// - In edge-only mode an acknowledge clears the latch at once, whatever the pin level.
// - The mask bit withholds the latched request without clearing the latch, and reset clears the mask.
// - A falling edge after a software acknowledge latches a new request.
// - Servicing the unmasked request loads the program counter from the vector at FFFA and FFFB.
// - The acknowledge bit is write-only, reads zero and is cleared by reset.
// - The read-only event flag reads one while the request latch is set and zero otherwise.
// - The CPU global interrupt mask also suppresses this block's request.
// - The current pin level is exposed to the CPU for branch-if-high and branch-if-low tests.
package epi_pkg;
  localparam logic [11:0] EPI_STATUS_CONTROL_OFS = 12'h000;
  localparam logic [11:0] EPI_IRQ_STATUS_OFS     = 12'h004;
  localparam logic [11:0] EPI_IRQ_MASK_OFS       = 12'h008;
  localparam int          EPI_SEL_BIT            = 0;
  localparam int          EPI_MASK_BIT           = 1;
  localparam int          EPI_ACK_BIT            = 2;
  localparam int          EPI_FLAG_BIT           = 3;
  localparam logic        EPI_SEL_RST            = 1'b0;
  localparam logic        EPI_MASK_RST           = 1'b0;
  localparam logic [15:0] EPI_VECTOR_HI_ADDR     = 16'hFFFA;
  localparam logic [15:0] EPI_VECTOR_LO_ADDR     = 16'hFFFB;
  localparam int          EPI_SYNC_STAGES        = 2;
  typedef enum logic [1:0] {
    EPI_IDLE    = 2'b00,
    EPI_PENDING = 2'b01,
    EPI_HOLD    = 2'b11
  } epi_state_e;
endpackage : epi_pkg

/* design/epi_sync.sv */
// Two-stage synchroniser for the interrupt pin.
`timescale 1ns/1ps
module epi_sync
  import epi_pkg::*;
#(
  parameter int STAGES = EPI_SYNC_STAGES
) (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin in, level out.
  input  wire logic async_in,
  output logic      sync_out
);
  logic [STAGES-1:0] chain;

  // A single stage would hand a metastable level to the edge detector.
  if (STAGES < 2) begin : g_bad_stages
    $error("epi_sync needs at least two stages.");
  end

  // The pin idles high, so reset loads ones to avoid a false edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain <= '1;
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
    end
  end

  assign sync_out = chain[STAGES-1];
endmodule : epi_sync

/* design/epi_apb_slave.sv */
// APB slave decode: zero-wait, with error on unmapped addresses.
`timescale 1ns/1ps
module epi_apb_slave
  import epi_pkg::*;
(
  // APB request.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  // APB answer.
  output logic             pready,
  output logic             pslverr,
  // Decoded strokes.
  output logic             wr_ctl,
  output logic             wr_sts,
  output logic             wr_msk,
  output logic             hit_ctl,
  output logic             hit_sts,
  output logic             hit_msk
);
  logic access;
  logic mapped;

  assign access  = psel && penable;
  assign hit_ctl = paddr == EPI_STATUS_CONTROL_OFS;
  assign hit_sts = paddr == EPI_IRQ_STATUS_OFS;
  assign hit_msk = paddr == EPI_IRQ_MASK_OFS;
  assign mapped  = hit_ctl || hit_sts || hit_msk;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign wr_ctl  = access && pwrite && hit_ctl;
  assign wr_sts  = access && pwrite && hit_sts;
  assign wr_msk  = access && pwrite && hit_msk;
endmodule : epi_apb_slave

/* design/epi_top.sv */
// External pin interrupt latch with APB registers and CPU-side signals.
`timescale 1ns/1ps
module epi_top
  import epi_pkg::*;
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // External active-low interrupt pin.
  input  wire logic        irq_pin_n,
  // CPU side.
  input  wire logic        cpu_global_mask,
  input  wire logic        vector_fetch,
  output logic             cpu_irq_req,
  output logic [15:0]      vector_addr_hi,
  output logic [15:0]      vector_addr_lo,
  output logic             pin_level,
  // Event interrupt.
  output logic             irq_out
);
  logic       pin_s;
  logic       pin_d;
  logic       fall;
  logic       wr_ctl;
  logic       wr_sts;
  logic       wr_msk;
  logic       hit_ctl;
  logic       hit_sts;
  logic       hit_msk;
  logic       edge_level_select_bit;
  logic       pin_request_mask_bit;
  logic       pin_request_latch;
  logic       ack;
  logic       sw_ack;
  logic       ack_seen;
  logic       set_req;
  logic       next_latch;
  logic       next_ack_seen;
  logic       irq_sticky;
  logic       irq_mask;
  logic       latch_d;
  logic [7:0] ctl_read;
  epi_state_e state;

  epi_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (irq_pin_n),
    .sync_out (pin_s)
  );

  epi_apb_slave u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pready  (pready),
    .pslverr (pslverr),
    .wr_ctl  (wr_ctl),
    .wr_sts  (wr_sts),
    .wr_msk  (wr_msk),
    .hit_ctl (hit_ctl),
    .hit_sts (hit_sts),
    .hit_msk (hit_msk)
  );

  // Edge detection looks only at the second synchroniser stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d <= 1'b1;
    end else begin
      pin_d <= pin_s;
    end
  end

  assign fall      = pin_d && !pin_s;
  assign pin_level = pin_s;

  // Control bits.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_level_select_bit <= EPI_SEL_RST;
      pin_request_mask_bit  <= EPI_MASK_RST;
    end else if (wr_ctl) begin
      edge_level_select_bit <= pwdata[EPI_SEL_BIT];
      pin_request_mask_bit  <= pwdata[EPI_MASK_BIT];
    end
  end

  assign sw_ack = wr_ctl && pwdata[EPI_ACK_BIT];
  assign ack    = sw_ack || vector_fetch;
  // A new edge or, in level mode, a low pin sets the latch.
  assign set_req = fall || (edge_level_select_bit && !pin_s);

  // Latch update. Set beats a coincident acknowledge, so an edge in the
  // acknowledge cycle is never lost.
  always_comb begin
    next_latch    = pin_request_latch;
    next_ack_seen = ack_seen;
    if (!pin_request_latch) begin
      next_ack_seen = 1'b0;
    end else if (!edge_level_select_bit) begin
      if (ack) next_latch = 1'b0;
      next_ack_seen = 1'b0;
    end else begin
      if (ack) next_ack_seen = 1'b1;
      if ((ack || ack_seen) && pin_s) begin
        next_latch    = 1'b0;
        next_ack_seen = 1'b0;
      end
    end
    if (set_req && !(ack && !edge_level_select_bit && !fall)) begin
      next_latch = 1'b1;
    end
    if (fall) next_latch = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_request_latch <= 1'b0;
      ack_seen          <= 1'b0;
    end else begin
      pin_request_latch <= next_latch;
      ack_seen          <= next_ack_seen;
    end
  end

  // State view of the latch for debug and checks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EPI_IDLE;
    end else begin
      case ({next_latch, next_ack_seen})
        2'b10:   state <= EPI_PENDING;
        2'b11:   state <= EPI_HOLD;
        default: state <= EPI_IDLE;
      endcase
    end
  end

  // Withholding does not touch the latch itself.
  assign cpu_irq_req = pin_request_latch && !pin_request_mask_bit
                       && !cpu_global_mask;
  assign vector_addr_hi = EPI_VECTOR_HI_ADDR;
  assign vector_addr_lo = EPI_VECTOR_LO_ADDR;

  // Sticky event bit set on each latch rise; write one clears, set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_d    <= 1'b0;
      irq_sticky <= 1'b0;
      irq_mask   <= 1'b0;
    end else begin
      latch_d <= pin_request_latch;
      if (pin_request_latch && !latch_d) begin
        irq_sticky <= 1'b1;
      end else if (wr_sts && pwdata[0]) begin
        irq_sticky <= 1'b0;
      end
      if (wr_msk) irq_mask <= pwdata[0];
    end
  end

  assign irq_out = irq_sticky && irq_mask;

  // The acknowledge bit always reads zero; the flag mirrors the latch.
  always_comb begin
    ctl_read               = 8'h00;
    ctl_read[EPI_SEL_BIT]  = edge_level_select_bit;
    ctl_read[EPI_MASK_BIT] = pin_request_mask_bit;
    ctl_read[EPI_ACK_BIT]  = 1'b0;
    ctl_read[EPI_FLAG_BIT] = pin_request_latch;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctl)      prdata <= {24'h00_0000, ctl_read};
      else if (hit_sts) prdata <= {31'h0000_0000, irq_sticky};
      else if (hit_msk) prdata <= {31'h0000_0000, irq_mask};
      else              prdata <= 32'h0000_0000;
    end
  end

  chk_fall_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall |=> pin_request_latch)
    else $error("Falling edge did not set latch.");

  chk_edge_ack_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ack && !edge_level_select_bit && !set_req) |=> !pin_request_latch)
    else $error("Edge-mode acknowledge did not clear latch.");

  chk_vf_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (vector_fetch && !edge_level_select_bit && !fall)
    |=> !pin_request_latch)
    else $error("Vector fetch did not clear latch.");

  chk_level_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_level_select_bit && !pin_s) |=> pin_request_latch)
    else $error("Low pin in level mode not pending.");

  chk_level_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_level_select_bit && pin_request_latch && !ack && !ack_seen)
    |=> pin_request_latch)
    else $error("Level latch cleared without acknowledge.");

  chk_hold_state: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == EPI_HOLD) |-> (pin_request_latch && ack_seen))
    else $error("Hold state without a remembered acknowledge.");

  chk_mask_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pin_request_mask_bit || cpu_global_mask) |-> !cpu_irq_req)
    else $error("Masked request reached the CPU.");

  chk_req_passes: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pin_request_latch && !pin_request_mask_bit && !cpu_global_mask)
    |-> cpu_irq_req)
    else $error("Unmasked request withheld from the CPU.");

  chk_sw_ack: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sw_ack && pin_s && !fall) |=> !pin_request_latch)
    else $error("Software acknowledge with high pin did not clear.");

  chk_flag_mirror: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_ctl)
    |=> prdata[EPI_FLAG_BIT] == $past(pin_request_latch))
    else $error("Event flag does not mirror latch.");

  chk_ack_reads_0: assert property (
    @(posedge pclk) disable iff (!presetn)
    !prdata[EPI_ACK_BIT])
    else $error("Acknowledge bit read as one.");

  chk_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(pin_request_latch) ##1 irq_mask |-> irq_out)
    else $error("Unmasked event did not raise interrupt.");
endmodule : epi_top

/* dv/epi_pin_source.sv */
// Behavioural external source that drives the interrupt pin.
`timescale 1ns/1ps
module epi_pin_source (
  // Clock.
  input  wire logic       pclk,
  // Commands from the bench.
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       hold,
  // Pin, idle high as if pulled up.
  output logic            irq_pin_n
);
  logic [7:0] cnt;
  initial cnt = 8'h00;
  // The pin moves just after an edge, so the design's synchroniser sees a
  // clean level; phase is not exercised, since the block has one clock.
  always_ff @(posedge pclk) begin
    if (go) begin
      cnt <= len;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
  assign irq_pin_n = ~(hold | (cnt != 8'h00));
endmodule : epi_pin_source

/* dv/epi_top_test.sv */
// Self-checking bench for the external pin interrupt latch.
`timescale 1ns/1ps
module epi_top_test
  import epi_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        pready, pslverr, erv, irq_pin_n;
  logic        cpu_global_mask, vector_fetch, cpu_irq_req;
  logic [15:0] vector_addr_hi, vector_addr_lo;
  logic        pin_level, irq_out, go, hold;
  logic [7:0]  len;
  int          bad_count, compares;
  localparam logic [11:0] C = EPI_STATUS_CONTROL_OFS;
  localparam logic [11:0] S = EPI_IRQ_STATUS_OFS;
  localparam logic [11:0] M = EPI_IRQ_MASK_OFS;

  epi_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pin_n(irq_pin_n), .cpu_global_mask(cpu_global_mask),
    .vector_fetch(vector_fetch), .cpu_irq_req(cpu_irq_req),
    .vector_addr_hi(vector_addr_hi), .vector_addr_lo(vector_addr_lo),
    .pin_level(pin_level), .irq_out(irq_out));
  epi_pin_source src (.pclk(pclk), .go(go), .len(len), .hold(hold),
    .irq_pin_n(irq_pin_n));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Called just after an edge; the answer is taken at the pready edge.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps a following call from re-driving psel at once.
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic pulse(input logic [7:0] n);
    go <= 1'b1;
    len <= n;
    @(posedge pclk);
    go <= 1'b0;
  endtask : pulse

  task automatic vf();
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
  endtask : vf

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial begin
    cyc(5000);
    bad_count++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cpu_global_mask = 1'b0;
    vector_fetch = 1'b0;
    go = 1'b0;
    len = 8'h00;
    hold = 1'b0;
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    rd(C); chk("ctl", 32'h0, rdv);
    chk("req", 32'h0, cpu_irq_req);
    chk("level", 32'h1, pin_level);
    chk("vec", 32'hFFFAFFFB, {vector_addr_hi, vector_addr_lo});
    done("reset");
    wr(M, 32'h1);
    hold <= 1'b1;
    cyc(5);
    chk("level", 32'h0, pin_level);
    chk("req", 32'h1, cpu_irq_req);
    chk("irq", 32'h1, irq_out);
    rd(C); chk("flag", 32'h8, rdv);
    wr(C, 32'h4);
    cyc(1);
    chk("req", 32'h0, cpu_irq_req);
    rd(C); chk("ack", 32'h0, rdv);
    rd(S); chk("sts", 32'h1, rdv);
    wr(S, 32'h1);
    cyc(1);
    chk("irq", 32'h0, irq_out);
    hold <= 1'b0;
    cyc(5);
    pulse(8'h03);
    cyc(5);
    chk("req", 32'h1, cpu_irq_req);
    done("edge");
    wr(C, 32'h2);
    cyc(1);
    chk("req", 32'h0, cpu_irq_req);
    rd(C); chk("ctl", 32'hA, rdv);
    wr(C, 32'h0);
    cpu_global_mask <= 1'b1;
    cyc(1);
    chk("req", 32'h0, cpu_irq_req);
    cpu_global_mask <= 1'b0;
    cyc(1);
    chk("req", 32'h1, cpu_irq_req);
    vf();
    cyc(1);
    chk("req", 32'h0, cpu_irq_req);
    done("mask");
    wr(C, 32'h1);
    hold <= 1'b1;
    cyc(5);
    vf();
    cyc(3);
    chk("req", 32'h1, cpu_irq_req);
    wr(C, 32'h3);
    chk("req", 32'h0, cpu_irq_req);
    wr(C, 32'h5);
    cyc(3);
    chk("req", 32'h1, cpu_irq_req);
    hold <= 1'b0;
    cyc(5);
    chk("req", 32'h0, cpu_irq_req);
    pulse(8'h03);
    cyc(8);
    chk("req", 32'h1, cpu_irq_req);
    wr(C, 32'h5);
    cyc(1);
    chk("req", 32'h0, cpu_irq_req);
    done("level");
    rd(12'h00C);
    chk("err", 32'h1, erv);
    chk("data", 32'h0, rdv);
    pulse(8'h03);
    cyc(6);
    presetn <= 1'b0;
    cyc(2);
    chk("req", 32'h0, cpu_irq_req);
    presetn <= 1'b1;
    cyc(1);
    rd(C); chk("ctl", 32'h0, rdv);
    done("misc");
    tally_and_finish();
  end
endmodule : epi_top_test
